/* File: rtl/pcs_consts.vh */
/*
  Offsets, field positions, reset values and fixed codes for the
  command/status and class/revision configuration registers.
  Assumes configuration offsets are byte addresses of whole dwords.
*/
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Dword-aligned configuration offsets
`define PCS_OFF_CMD_STAT      8'h04
`define PCS_OFF_CLASS_REV     8'h08

// Command half
`define PCS_BIT_PERR_RESP     6
`define PCS_BIT_SERR_EN       8
`define PCS_BIT_FB2B_EN       9
`define PCS_RST_PERR_RESP     1'h0
`define PCS_RST_SERR_EN       1'h0
`define PCS_RST_FB2B_EN       1'h0

// Status half, constant fields
`define PCS_BIT_CAP_LIST      20
`define PCS_BIT_CAP_66M       21
`define PCS_BIT_FB2B_CAP      23
`define PCS_VAL_CAP_LIST      1'h1
`define PCS_VAL_CAP_66M       1'h0
`define PCS_VAL_FB2B_CAP      1'h1
`define PCS_LSB_DEVSEL        25
`define PCS_VAL_DEVSEL        2'h1

// Sticky error flags, positions 24 and 27..31
`define PCS_BIT_MDPERR        24
`define PCS_BIT_SIG_TABT      27
`define PCS_BIT_RCV_TABT      28
`define PCS_BIT_RCV_MABT      29
`define PCS_BIT_SIG_SERR      30
`define PCS_BIT_DET_PERR      31
`define PCS_RST_ERR_FLAGS     6'h00

// Class/revision fields
`define PCS_BASE_CLASS        8'h01
`define PCS_SUB_IDE           8'h01
`define PCS_SUB_RAID          8'h04
`define PCS_RST_SUB_CLASS     8'h01
`define PCS_PROGIF_NONE       8'h00

`endif

/* File: rtl/pcs_config_regs.v */
/*
  Command/status and class/revision configuration registers of a
  bus-mastering mass-storage controller, with the sticky error flags
  and the system-error and parity-error drive requests.
  Assumes the configuration decoder and bus engine run on the same
  clock and hand over dword accesses and one-cycle error events.
*/
`timescale 1ns/1ps
`include "pcs_consts.vh"

module pcs_config_regs
#(
  // Arbitrary neutral revision value
  parameter [7:0] REVISION_ID = 8'h5a
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        cfg_req,
  input  wire        cfg_we,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_ack,
  input  wire [7:0]  progif_in,
  input  wire        ev_addr_perr,
  input  wire        ev_data_perr,
  input  wire        ev_master_perr,
  input  wire        ev_sig_tabort,
  input  wire        ev_rcv_tabort,
  input  wire        ev_rcv_mabort,
  input  wire        ev_special_cyc,
  output reg         serr_o,
  output reg         serr_oe,
  output reg         perr_drive,
  output reg         perr_resp_en,
  output reg         serr_en,
  output reg         ide_mode
);

  reg        perr_resp_q;
  reg        serr_en_q;
  reg        mdperr_q;
  reg        sig_tabt_q;
  reg        rcv_tabt_q;
  reg        rcv_mabt_q;
  reg        sig_serr_q;
  reg        det_perr_q;
  reg  [7:0] sub_class_q;
  reg        perr_resp_d;
  reg        serr_en_d;
  reg  [7:0] sub_class_d;
  reg [31:0] rdata_d;

  wire       wr_cmd;
  wire       wr_cls;
  wire       rd_go;
  wire       serr_fire;
  wire       mdperr_set;
  wire       det_perr_set;
  wire       mabt_set;
  wire [7:0] progif_v;
  wire [7:0] clr;

  // Write-one-to-clear mask for one sticky flag in the top byte
  function w1c;
    input       be3;
    input       we;
    input [7:0] wbyte;
    input [2:0] pos;
    begin
      w1c = we & be3 & wbyte[pos];
    end
  endfunction

  // Set has priority over a same-cycle clear
  function sticky;
    input q;
    input set;
    input c;
    begin
      sticky = (q & ~c) | set;
    end
  endfunction

  // Offset match, shared by the write strobes and the read mux
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Sub-class code meaning IDE, read by the interface byte and the mode
  function is_ide;
    input [7:0] code;
    begin
      is_ide = (code == `PCS_SUB_IDE);
    end
  endfunction

  // Only the two listed controller kinds may be stored
  function sub_ok;
    input [7:0] code;
    begin
      sub_ok = (code == `PCS_SUB_IDE) || (code == `PCS_SUB_RAID);
    end
  endfunction

  assign wr_cmd = cfg_req & cfg_we & hit(cfg_addr, `PCS_OFF_CMD_STAT);
  assign wr_cls = cfg_req & cfg_we & hit(cfg_addr, `PCS_OFF_CLASS_REV);
  assign rd_go  = cfg_req & ~cfg_we;

  assign clr[0] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h0);
  // Top-byte bits 1 and 2 are fixed status fields, never cleared
  assign clr[1] = 1'b0;
  assign clr[2] = 1'b0;
  assign clr[3] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h3);
  assign clr[4] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h4);
  assign clr[5] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h5);
  assign clr[6] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h6);
  assign clr[7] = w1c(cfg_be[3], wr_cmd, cfg_wdata[31:24], 3'h7);

  // Address parity only escalates when both enables are on
  assign serr_fire = ev_addr_perr & serr_en_q & perr_resp_q;
  assign mdperr_set = ev_master_perr & perr_resp_q;
  // Logged even with parity response off
  assign det_perr_set = ev_addr_perr | ev_data_perr;
  assign mabt_set = ev_rcv_mabort & ~ev_special_cyc;

  // Interface byte has meaning only while classed as IDE
  assign progif_v = is_ide(sub_class_q) ?
                    progif_in : `PCS_PROGIF_NONE;

  // Next command and sub-class values; stored bits and output copies
  // both load these; the copies match the registers except in reset, where ide_mode is 0 while the sub-class is IDE
  always @*
  begin
    perr_resp_d = perr_resp_q;
    serr_en_d   = serr_en_q;
    sub_class_d = sub_class_q;
    if (wr_cmd)
    begin
      if (cfg_be[0])
        perr_resp_d = cfg_wdata[`PCS_BIT_PERR_RESP];
      if (cfg_be[1])
        serr_en_d = cfg_wdata[`PCS_BIT_SERR_EN];
    end
    else if (wr_cls)
    begin
      // Codes other than IDE or RAID are dropped, not stored
      if (cfg_be[2] && sub_ok(cfg_wdata[23:16]))
        sub_class_d = cfg_wdata[23:16];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      perr_resp_q <= `PCS_RST_PERR_RESP;
      serr_en_q   <= `PCS_RST_SERR_EN;
      sub_class_q <= `PCS_RST_SUB_CLASS;
    end
    else
    begin
      perr_resp_q <= perr_resp_d;
      serr_en_q   <= serr_en_d;
      sub_class_q <= sub_class_d;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mdperr_q   <= 1'b0;
      sig_tabt_q <= 1'b0;
      rcv_tabt_q <= 1'b0;
      rcv_mabt_q <= 1'b0;
      sig_serr_q <= 1'b0;
      det_perr_q <= 1'b0;
    end
    else
    begin
      // Hardware sets, software writes one to clear
      mdperr_q   <= sticky(mdperr_q, mdperr_set, clr[0]);
      sig_tabt_q <= sticky(sig_tabt_q, ev_sig_tabort, clr[3]);
      rcv_tabt_q <= sticky(rcv_tabt_q, ev_rcv_tabort, clr[4]);
      rcv_mabt_q <= sticky(rcv_mabt_q, mabt_set, clr[5]);
      sig_serr_q <= sticky(sig_serr_q, serr_fire, clr[6]);
      det_perr_q <= sticky(det_perr_q, det_perr_set, clr[7]);
    end
  end

  // Pin drive requests, one-cycle pulses
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serr_o     <= 1'b0;
      serr_oe    <= 1'b0;
      perr_drive <= 1'b0;
    end
    else
    begin
      // Open drain: low level while enabled, released otherwise
      serr_o     <= 1'b0;
      serr_oe    <= serr_fire;
      // No parity drive unless response is enabled
      perr_drive <= ev_data_perr & perr_resp_q;
    end
  end

  // Mirrors of command and mode state for the bus engine; loaded from
  // the next value, but ide_mode resets to 0 while the stored sub-class resets to IDE
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      perr_resp_en <= `PCS_RST_PERR_RESP;
      serr_en      <= `PCS_RST_SERR_EN;
      ide_mode     <= 1'b0;
    end
    else
    begin
      perr_resp_en <= perr_resp_d;
      serr_en      <= serr_en_d;
      ide_mode     <= is_ide(sub_class_d);
    end
  end

  // Read word for the addressed register; other offsets read as zero
  always @*
  begin
    rdata_d = 32'h00000000;
    if (hit(cfg_addr, `PCS_OFF_CMD_STAT))
    begin
      rdata_d[`PCS_BIT_PERR_RESP] = perr_resp_q;
      rdata_d[`PCS_BIT_SERR_EN]   = serr_en_q;
      rdata_d[`PCS_BIT_FB2B_EN]   = `PCS_RST_FB2B_EN;
      // Reserved command and low status bits stay zero
      rdata_d[15:10]              = 6'h00;
      rdata_d[19:16]              = 4'h0;
      rdata_d[22]                 = 1'b0;
      rdata_d[`PCS_BIT_CAP_LIST]  = `PCS_VAL_CAP_LIST;
      rdata_d[`PCS_BIT_CAP_66M]   = `PCS_VAL_CAP_66M;
      rdata_d[`PCS_BIT_FB2B_CAP]  = `PCS_VAL_FB2B_CAP;
      rdata_d[`PCS_BIT_MDPERR]    = mdperr_q;
      rdata_d[`PCS_LSB_DEVSEL+1:`PCS_LSB_DEVSEL]
                                  = `PCS_VAL_DEVSEL;
      rdata_d[`PCS_BIT_SIG_TABT]  = sig_tabt_q;
      rdata_d[`PCS_BIT_RCV_TABT]  = rcv_tabt_q;
      rdata_d[`PCS_BIT_RCV_MABT]  = rcv_mabt_q;
      rdata_d[`PCS_BIT_SIG_SERR]  = sig_serr_q;
      rdata_d[`PCS_BIT_DET_PERR]  = det_perr_q;
    end
    else if (hit(cfg_addr, `PCS_OFF_CLASS_REV))
    begin
      rdata_d[31:24] = `PCS_BASE_CLASS;
      rdata_d[23:16] = sub_class_q;
      rdata_d[15:8]  = progif_v;
      rdata_d[7:0]   = REVISION_ID;
    end
  end

  // Answer one cycle after the request; data holds until the next read
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_rdata <= 32'h00000000;
      cfg_ack   <= 1'b0;
    end
    else
    begin
      cfg_ack <= cfg_req;
      if (rd_go)
        cfg_rdata <= rdata_d;
    end
  end

endmodule

/* File: test/pcs_host_model.sv */
/* Config-cycle master model for the register block.
   Assumes the block acknowledges one cycle after each request. */
`timescale 1ns/1ps
module pcs_host_model
(
  input  wire        clk,
  output reg         req,
  output reg         we,
  output reg  [7:0]  addr,
  output reg  [3:0]  be,
  output reg  [31:0] wd,
  input  wire        ack,
  input  wire [31:0] rd
);
  initial
  begin
    {req, we, addr, be, wd} = 46'h0;
  end
  task xfer(input w, input [7:0] a, input [3:0] b, input [31:0] d,
            output [31:0] q, output ok);
    begin
      @(posedge clk);
      req <= 1'b1;
      {we, addr, be, wd} <= {w, a, b, d};
      @(posedge clk);
      req <= 1'b0;
      // Released lines show junk, not the last value
      {we, addr, be, wd} <= ~{w, a, b, d};
      #1;
      ok = (ack === 1'b1);
      q = rd;
    end
  endtask
endmodule

/* File: test/pcs_config_props.sv */
/* Port-level checks of the command/status and class registers.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module pcs_config_props
(
  input wire        clk,
  input wire        rst,
  input wire        cfg_req,
  input wire        cfg_we,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_rdata,
  input wire        ev_addr_perr,
  input wire        serr_oe,
  input wire        perr_drive,
  input wire        perr_resp_en,
  input wire        serr_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    cfg_req && !cfg_we && cfg_addr == a;
  endsequence
  property p_serr;
    ev_addr_perr && serr_en && perr_resp_en |=> serr_oe;
  endproperty
  property p_serr_cause;
    serr_oe |-> $past(ev_addr_perr) && $past(serr_en) && $past(perr_resp_en);
  endproperty
  property p_perr;
    perr_drive |-> $past(perr_resp_en);
  endproperty
  property p_fixed;
    s_rd(8'h04) |=> cfg_rdata[23:9] == 15'h4800;
  endproperty
  property p_devsel;
    s_rd(8'h04) |=> cfg_rdata[26:25] == 2'h1;
  endproperty
  property p_class;
    s_rd(8'h08) |=> cfg_rdata[31:24] == 8'h01;
  endproperty
  property p_sub;
    s_rd(8'h08) |=> cfg_rdata[23:16] inside {8'h01, 8'h04};
  endproperty
  property p_progif;
    s_rd(8'h08) |=> cfg_rdata[23:16] != 8'h04 || cfg_rdata[15:8] == 8'h00;
  endproperty
  property p_unmapped;
    cfg_req && !cfg_we && cfg_addr != 8'h04 && cfg_addr != 8'h08
      |=> cfg_rdata == 32'h0;
  endproperty
  a_serr: assert property (p_serr)
    else $error("system error not driven");
  a_serr_cause: assert property (p_serr_cause)
    else $error("system error without cause");
  a_perr: assert property (p_perr)
    else $error("parity drive while response off");
  a_fixed: assert property (p_fixed)
    else $error("fixed status bits wrong");
  a_devsel: assert property (p_devsel)
    else $error("select timing wrong");
  a_class: assert property (p_class)
    else $error("base class wrong");
  a_sub: assert property (p_sub)
    else $error("sub-class out of set");
  a_progif: assert property (p_progif)
    else $error("interface byte set outside IDE");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

/* File: test/pci_config_command_status_bench.sv */
/* Self-checking bench for the configuration register block.
   Assumes the host model issues every register access. */
`timescale 1ns/1ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
  err_total = err_total + 1; $display("[ERR] %0t %h %h", $time, a, e); end end
module pci_config_command_status_bench;
  reg         clk;
  reg         rst;
  reg  [6:0]  ev_v;
  wire        req, we, ack, serr_oe, perr_drive, perr_en, serr_en, ide;
  wire [7:0]  addr;
  wire [3:0]  be;
  wire        serr_o;
  wire [31:0] wd, rd;
  reg  [31:0] q;
  reg         ok;
  reg  [44:0] rows [0:9];
  integer     err_total, checked, i;
  pcs_config_regs #(.REVISION_ID(8'h5a)) pcs_config_regs_inst (
    .clk(clk), .rst(rst),
    .cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_be(be),
    .cfg_wdata(wd), .cfg_rdata(rd), .cfg_ack(ack), .progif_in(8'ha5),
    .ev_addr_perr(ev_v[6]), .ev_data_perr(ev_v[5]),
    .ev_master_perr(ev_v[4]), .ev_sig_tabort(ev_v[3]),
    .ev_rcv_tabort(ev_v[2]), .ev_rcv_mabort(ev_v[1]),
    .ev_special_cyc(ev_v[0]), .serr_o(serr_o), .serr_oe(serr_oe),
    .perr_drive(perr_drive), .perr_resp_en(perr_en),
    .serr_en(serr_en), .ide_mode(ide));
  pcs_host_model pcs_host_model_inst (.clk(clk), .req(req), .we(we),
    .addr(addr), .be(be), .wd(wd), .ack(ack), .rd(rd));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task wrap_up;
    begin
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task acc(input w, input [7:0] a, input [3:0] b, input [31:0] d);
    begin
      pcs_host_model_inst.xfer(w, a, b, d, q, ok);
      if (!ok)
      begin
        err_total = err_total + 1;
        wrap_up;
      end
    end
  endtask
  // Event inputs are sampled at the second edge
  task pulse(input [6:0] v);
    begin
      @(posedge clk);
      ev_v <= v;
      @(posedge clk);
      ev_v <= 7'h00;
      #1;
    end
  endtask
  initial
  begin
    rst = 1'b1;
    ev_v = 7'h00;
    err_total = 0;
    checked = 0;
    rows[0] = {1'b0, 8'h04, 4'h0, 32'h02900000};
    rows[1] = {1'b0, 8'h08, 4'h0, 32'h0101a55a};
    rows[2] = {1'b1, 8'h04, 4'hf, 32'hffffffff};
    rows[3] = {1'b0, 8'h04, 4'h0, 32'h02900140};
    rows[4] = {1'b1, 8'h08, 4'hf, 32'hffffffff};
    rows[5] = {1'b0, 8'h08, 4'h0, 32'h0101a55a};
    rows[6] = {1'b1, 8'h08, 4'h4, 32'h00040000};
    rows[7] = {1'b0, 8'h08, 4'h0, 32'h0104005a};
    rows[8] = {1'b1, 8'h0c, 4'hf, 32'hffffffff};
    rows[9] = {1'b0, 8'h0c, 4'h0, 32'h00000000};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 10; i = i + 1)
    begin
      acc(rows[i][44], rows[i][43:36], rows[i][35:32], rows[i][31:0]);
      if (!rows[i][44])
        `CHK(q, rows[i][31:0])
    end
    `CHK(ide, 1'b0)
    `CHK(perr_en, 1'b1)
    `CHK(serr_en, 1'b1)
    pulse(7'h40);
    `CHK(serr_oe, 1'b1)
    `CHK(serr_o, 1'b0)
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'hc2900140)
    pulse(7'h1e);
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'hfb900140)
    acc(1'b1, 8'h04, 4'h8, 32'h0);
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'hfb900140)
    pulse(7'h20);
    `CHK(perr_drive, 1'b1)
    // Clear and a new target-abort event meet at one edge: set wins
    fork
      acc(1'b1, 8'h04, 4'h8, 32'hff000000);
      pulse(7'h08);
    join
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'h0a900140)
    acc(1'b1, 8'h04, 4'hb, 32'hff000100);
    `CHK(perr_en, 1'b0)
    pulse(7'h73);
    `CHK(serr_oe, 1'b0)
    `CHK(perr_drive, 1'b0)
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'h82900100)
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 8'h04, 4'h0, 32'h0);
    `CHK(q, 32'h02900000)
    `CHK(serr_en, 1'b0)
    `CHK(ide, 1'b1)
    wrap_up;
  end
endmodule
bind pcs_config_regs pcs_config_props pcs_config_props_inst (
  .clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .ev_addr_perr(ev_addr_perr), .serr_oe(serr_oe),
  .perr_drive(perr_drive), .perr_resp_en(perr_resp_en),
  .serr_en(serr_en));
